// ### logic/pwha_core.sv
// Hardware approach controller: interval timer, phase sequencing and the
// stepping of the 9-bit pulse width toward two targets.
// Assumes configuration ports are driven from the CPU clock domain and that
// the over-voltage and pulse trigger inputs are asynchronous pins.
//
// Notes on behaviour
// - Trigger source select picks timer start source.
// - Start on over-voltage edge or timer-on rise.
// - Hold interval keeps pulse width fixed.
// - First approach interval steps toward first target.
// - After set step count, adjust count and step.
// - Stop stepping once first target equal.
// - Second approach interval steps toward second target.
// - Idle interval: timer off, software free.
// - Width, count, step writes blocked while approaching.
// - Set first flag on match; software only clears.
// - Over-voltage fall or timer-on rise clears flag.
// - Second flag: same set and clear behaviour.
// - Clearing mode select ends hardware approach.
// - Two-bit phase field; enable in approach codes.
// - Selecting hardware mode clears timer-on bit.
// - Source zero: over-voltage edge starts action.
// - Edge select picks over-voltage active polarity.
// - Prescaler select picks timer clock rate.
// - Step plus one per count plus one triggers.
// - Count adjust 10B adds one to count.
// - Clamp stepped width to 0 and 511.
// - Overshoot once, then load target exactly.
`timescale 1ns/1ps
`default_nettype none
module pwha_core
  import pwha_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire pwha_cfg_type cfg_i,
  input wire pwha_period_type periods_i,
  input wire logic [PW_W-1:0] first_target_width_i,
  input wire logic [7:0] wr_byte_i,
  input wire logic pw_hi_wr_i,
  input wire logic pw_lo_wr_i,
  input wire logic tgt2_hi_wr_i,
  input wire logic tgt2_lo_wr_i,
  input wire logic field_wr_i,
  input wire logic [CNT_W-1:0] trigger_count_wdata_i,
  input wire logic [STEP_W-1:0] step_size_wdata_i,
  input wire logic timer_on_wr_i,
  input wire logic timer_on_wdata_i,
  input wire logic flag1_clr_i,
  input wire logic flag2_clr_i,
  input wire logic overvoltage_interrupt_i,
  input wire logic pulse_trigger_input_i,
  output logic [PW_W-1:0] pulse_width_value_o,
  output logic [PW_W-1:0] second_target_width_o,
  output logic [CNT_W-1:0] trigger_count_field_o,
  output logic [STEP_W-1:0] step_size_field_o,
  output logic [TMR_W-1:0] interval_timer_o,
  output pwha_status_type status_o
);

  // One approach step; a step past the target is followed by an exact load.
  function automatic logic [PW_W-1:0] step_width(
    input logic [PW_W-1:0] pw,
    input logic [PW_W-1:0] tgt,
    input logic [STEP_W-1:0] step,
    input logic up
  );
    logic [PW_W:0] sum;
    logic [PW_W:0] dif;
    sum = {1'b0, pw} + {7'h00, step} + 10'h001;
    dif = {1'b0, pw} - {7'h00, step} - 10'h001;
    if (up && pw > tgt) begin
      step_width = tgt;
    end else if (!up && pw < tgt) begin
      step_width = tgt;
    end else if (pw < tgt) begin
      step_width = sum[PW_W] ? PW_MAX : sum[PW_W-1:0];
    end else begin
      step_width = dif[PW_W] ? PW_RST : dif[PW_W-1:0];
    end
  endfunction

  // Saturating adjust of a small field by one, by adjust code.
  function automatic logic [STEP_W-1:0] adjust_field(
    input logic [STEP_W-1:0] val,
    input logic [STEP_W-1:0] max,
    input logic [1:0] code
  );
    adjust_field = val;
    if (code == ADJ_INC && val != max) begin
      adjust_field = val + 3'h1;
    end else if (code == ADJ_DEC && val != STEP_RST) begin
      adjust_field = val - 3'h1;
    end
  endfunction

  // Two-flop synchronisers plus a third stage for edge detection.
  logic ovp_meta, ovp_sync, ovp_prev;
  logic trg_meta, trg_sync, trg_prev;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovp_meta <= 1'b0;
      ovp_sync <= 1'b0;
      ovp_prev <= 1'b0;
      trg_meta <= 1'b1;
      trg_sync <= 1'b1;
      trg_prev <= 1'b1;
    end else begin
      ovp_meta <= overvoltage_interrupt_i;
      ovp_sync <= ovp_meta;
      ovp_prev <= ovp_sync;
      trg_meta <= pulse_trigger_input_i;
      trg_sync <= trg_meta;
      trg_prev <= trg_sync;
    end
  end

  pwha_phase_type phase, next_phase;
  logic [TMR_W-1:0] timer, next_timer;
  logic [PSC_W-1:0] psc, next_psc;
  logic [PW_W-1:0] pw, next_pw;
  logic [PW_W-1:0] tgt2, next_tgt2;
  logic [7:0] pw_hi, next_pw_hi;
  logic [7:0] tgt2_hi, next_tgt2_hi;
  logic [CNT_W-1:0] tcnt, next_tcnt;
  logic [STEP_W-1:0] step, next_step;
  logic [CNT_W-1:0] trig_cnt, next_trig_cnt;
  logic [TIMES_W-1:0] step_cnt, next_step_cnt;
  logic adjusted, next_adjusted;
  logic done, next_done;
  logic dir_up, next_dir_up;
  logic timer_on, next_timer_on;
  logic flag1, next_flag1;
  logic flag2, next_flag2;
  logic mode_prev, next_mode_prev;

  logic ovp_rise, ovp_fall, ovp_act, trig, on_rise, tick, ovf, start;
  logic approaching, locked;
  logic [PSC_W-1:0] psc_mask;
  logic [PW_W-1:0] tgt;
  logic [STEP_W-1:0] tcnt_wide;

  // Event decode shared by the sequencer.
  always_comb begin
    ovp_rise = ovp_sync & ~ovp_prev;
    ovp_fall = ~ovp_sync & ovp_prev;
    ovp_act = cfg_i.overvoltage_edge_select ? ovp_rise : ovp_fall;
    trig = ~trg_sync & trg_prev;
    on_rise = timer_on_wr_i & timer_on_wdata_i & ~timer_on;
    psc_mask = PSC_W'((4'h1 << cfg_i.timer_clock_select) - 4'h1);
    tick = (psc == psc_mask);
    approaching = (phase == PWHA_FIRST) || (phase == PWHA_SECOND);
    locked = cfg_i.approach_mode_select & approaching;
    ovf = (phase != PWHA_IDLE) && tick && (timer == TMR_MAX);
    // A start is only accepted from idle so a run cannot be cut short; the
    // cycle that enters hardware mode takes none, so timer-on stays cleared.
    start = cfg_i.approach_mode_select && mode_prev &&
            (phase == PWHA_IDLE) &&
            (cfg_i.hw_trigger_source_select ? on_rise : ovp_act);
    tgt = (phase == PWHA_SECOND) ? tgt2 : first_target_width_i;
    tcnt_wide = {1'b0, tcnt};
  end

  // Next state of the sequencer, width, fields and flags.
  always_comb begin
    next_phase = phase;
    next_timer = timer;
    next_psc = psc;
    next_pw = pw;
    next_tgt2 = tgt2;
    next_pw_hi = pw_hi;
    next_tgt2_hi = tgt2_hi;
    next_tcnt = tcnt;
    next_step = step;
    next_trig_cnt = trig_cnt;
    next_step_cnt = step_cnt;
    next_adjusted = adjusted;
    next_done = done;
    next_dir_up = dir_up;
    next_timer_on = timer_on;
    next_flag1 = flag1;
    next_flag2 = flag2;
    next_mode_prev = cfg_i.approach_mode_select;

    // Software side; the low byte commits the buffered high byte.
    if (pw_hi_wr_i) begin
      next_pw_hi = wr_byte_i;
    end
    if (tgt2_hi_wr_i) begin
      next_tgt2_hi = wr_byte_i;
    end
    if (pw_lo_wr_i && !locked) begin
      next_pw = {pw_hi[0], wr_byte_i};
    end
    if (tgt2_lo_wr_i) begin
      next_tgt2 = {tgt2_hi[0], wr_byte_i};
    end
    if (field_wr_i && !locked) begin
      next_tcnt = trigger_count_wdata_i;
      next_step = step_size_wdata_i;
    end
    if (timer_on_wr_i) begin
      next_timer_on = timer_on_wdata_i;
    end
    if (cfg_i.approach_mode_select && !mode_prev) begin
      next_timer_on = 1'b0;
    end

    // Clears first, so a same-cycle hardware set below wins.
    if (flag1_clr_i || ovp_fall || on_rise) begin
      next_flag1 = 1'b0;
    end
    if (flag2_clr_i || ovp_fall || on_rise) begin
      next_flag2 = 1'b0;
    end

    // Prescaler runs only while the interval timer runs.
    if (phase != PWHA_IDLE) begin
      next_psc = tick ? PSC_RST : psc + 3'h1;
      if (tick) begin
        next_timer = timer + 16'h0001;
      end
    end

    // Stepping toward the current target in either approach phase.
    if (approaching && !done) begin
      if (pw == tgt) begin
        next_done = 1'b1;
        if (phase == PWHA_FIRST) begin
          next_flag1 = 1'b1;
        end else begin
          next_flag2 = 1'b1;
        end
      end else if (trig) begin
        if (trig_cnt == tcnt) begin
          next_trig_cnt = CNT_RST;
          next_pw = step_width(pw, tgt, step, dir_up);
          next_step_cnt = step_cnt + 3'h1;
          if (!adjusted && step_cnt == cfg_i.approach_count_setting) begin
            next_adjusted = 1'b1;
            next_tcnt = CNT_W'(adjust_field(tcnt_wide, {1'b0, CNT_MAX},
                                            cfg_i.count_adjust_setting));
            next_step = adjust_field(step, STEP_MAX,
                                     cfg_i.step_adjust_setting);
          end
        end else begin
          next_trig_cnt = trig_cnt + 2'h1;
        end
      end
    end

    // Phase sequencing; hold and first overflows reload the next period, second goes idle.
    case (phase)
      PWHA_IDLE: begin
        if (start) begin
          next_phase = PWHA_HOLD;
          next_timer = periods_i.hold_period_value;
          next_psc = PSC_RST;
          next_timer_on = 1'b1;
        end
      end
      PWHA_HOLD: begin
        if (ovf) begin
          next_phase = PWHA_FIRST;
          next_timer = periods_i.first_approach_period_value;
          next_dir_up = pw < first_target_width_i;
        end
      end
      PWHA_FIRST: begin
        if (ovf) begin
          next_phase = PWHA_SECOND;
          next_timer = periods_i.second_approach_period_value;
          next_dir_up = next_pw < tgt2;
        end
      end
      PWHA_SECOND: begin
        if (ovf) begin
          next_phase = PWHA_IDLE;
          next_timer_on = 1'b0;
        end
      end
      default: begin
        next_phase = PWHA_IDLE;
      end
    endcase

    // Every approach phase starts with fresh counters.
    if (ovf && (phase == PWHA_HOLD || phase == PWHA_FIRST)) begin
      next_trig_cnt = CNT_RST;
      next_step_cnt = TIMES_RST;
      next_adjusted = 1'b0;
      next_done = 1'b0;
    end

    // Leaving hardware mode abandons the run at once.
    if (!cfg_i.approach_mode_select && phase != PWHA_IDLE) begin
      next_phase = PWHA_IDLE;
      next_timer_on = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= PWHA_IDLE;
      timer <= TMR_RST;
      psc <= PSC_RST;
      pw <= PW_RST;
      tgt2 <= PW_RST;
      pw_hi <= 8'h00;
      tgt2_hi <= 8'h00;
      tcnt <= CNT_RST;
      step <= STEP_RST;
      trig_cnt <= CNT_RST;
      step_cnt <= TIMES_RST;
      adjusted <= 1'b0;
      done <= 1'b0;
      dir_up <= 1'b0;
      timer_on <= 1'b0;
      flag1 <= 1'b0;
      flag2 <= 1'b0;
      mode_prev <= 1'b0;
    end else begin
      phase <= next_phase;
      timer <= next_timer;
      psc <= next_psc;
      pw <= next_pw;
      tgt2 <= next_tgt2;
      pw_hi <= next_pw_hi;
      tgt2_hi <= next_tgt2_hi;
      tcnt <= next_tcnt;
      step <= next_step;
      trig_cnt <= next_trig_cnt;
      step_cnt <= next_step_cnt;
      adjusted <= next_adjusted;
      done <= next_done;
      dir_up <= next_dir_up;
      timer_on <= next_timer_on;
      flag1 <= next_flag1;
      flag2 <= next_flag2;
      mode_prev <= next_mode_prev;
    end
  end

  // Outputs straight from state except approach_enable, gated by the mode select input; the phase code maps from the enum.
  always_comb begin
    pulse_width_value_o = pw;
    second_target_width_o = tgt2;
    trigger_count_field_o = tcnt;
    step_size_field_o = step;
    interval_timer_o = timer;
    case (phase)
      PWHA_HOLD: status_o.timer_phase_field = PHASE_CODE_HOLD;
      PWHA_FIRST: status_o.timer_phase_field = PHASE_CODE_FIRST;
      PWHA_SECOND: status_o.timer_phase_field = PHASE_CODE_SECOND;
      default: status_o.timer_phase_field = PHASE_CODE_IDLE;
    endcase
    status_o.approach_enable = locked;
    status_o.interval_timer_on = timer_on;
    status_o.first_target_reached_flag = flag1;
    status_o.second_target_reached_flag = flag2;
  end

endmodule
`default_nettype wire

// ### logic/pwha_pkg.sv
// Shared constants and carrier types for the hardware approach controller.
// Assumes a single system clock domain and one controller instance.
package pwha_pkg;

  localparam int PW_W = 9;
  localparam int TMR_W = 16;
  localparam int CNT_W = 2;
  localparam int STEP_W = 3;
  localparam int TIMES_W = 3;
  localparam int PSC_W = 3;

  localparam logic [PW_W-1:0] PW_MAX = 9'h1FF;
  localparam logic [PW_W-1:0] PW_RST = 9'h000;
  localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 2'h3;
  localparam logic [STEP_W-1:0] STEP_RST = 3'h0;
  localparam logic [STEP_W-1:0] STEP_MAX = 3'h7;
  localparam logic [TIMES_W-1:0] TIMES_RST = 3'h0;
  localparam logic [PSC_W-1:0] PSC_RST = 3'h0;

  // Phase field codes as software reads them.
  localparam logic [1:0] PHASE_CODE_HOLD = 2'h0;
  localparam logic [1:0] PHASE_CODE_FIRST = 2'h1;
  localparam logic [1:0] PHASE_CODE_SECOND = 2'h2;
  localparam logic [1:0] PHASE_CODE_IDLE = 2'h3;

  // Adjust setting encodings; other codes leave the field unchanged.
  localparam logic [1:0] ADJ_DEC = 2'h1;
  localparam logic [1:0] ADJ_INC = 2'h2;

  typedef enum logic [1:0] {
    PWHA_HOLD,
    PWHA_FIRST,
    PWHA_SECOND,
    PWHA_IDLE
  } pwha_phase_type;

  typedef struct packed {
    logic approach_mode_select;
    logic hw_trigger_source_select;
    logic overvoltage_edge_select;
    logic [1:0] timer_clock_select;
    logic [TIMES_W-1:0] approach_count_setting;
    logic [1:0] count_adjust_setting;
    logic [1:0] step_adjust_setting;
  } pwha_cfg_type;

  typedef struct packed {
    logic [TMR_W-1:0] hold_period_value;
    logic [TMR_W-1:0] first_approach_period_value;
    logic [TMR_W-1:0] second_approach_period_value;
  } pwha_period_type;

  typedef struct packed {
    logic [1:0] timer_phase_field;
    logic approach_enable;
    logic interval_timer_on;
    logic first_target_reached_flag;
    logic second_target_reached_flag;
  } pwha_status_type;

endpackage

// ### testbench/pwha_props.sv
// Checker for the approach controller, bound to every pwha_core.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pwha_props
  import pwha_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire pwha_cfg_type cfg_i,
  input wire pwha_period_type periods_i,
  input wire logic [PW_W-1:0] first_target_width_i,
  input wire logic pw_lo_wr_i,
  input wire logic flag1_clr_i,
  input wire logic [PW_W-1:0] pulse_width_value_o,
  input wire logic [PW_W-1:0] second_target_width_o,
  input wire logic [TMR_W-1:0] interval_timer_o,
  input wire pwha_status_type status_o
);
  logic [1:0] ph;
  logic md;
  logic f1;
  logic f2;
  // Short aliases keep the properties inside the line width.
  assign ph = status_o.timer_phase_field;
  assign md = cfg_i.approach_mode_select;
  assign f1 = status_o.first_target_reached_flag;
  assign f2 = status_o.second_target_reached_flag;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Each interval entry is a pair of phase codes on two edges.
  sequence s_to_hold;
    ph == PHASE_CODE_IDLE ##1 ph == PHASE_CODE_HOLD;
  endsequence
  sequence s_to_first;
    ph == PHASE_CODE_HOLD ##1 ph == PHASE_CODE_FIRST;
  endsequence
  sequence s_to_second;
    ph == PHASE_CODE_FIRST ##1 ph == PHASE_CODE_SECOND;
  endsequence
  property p_start;
    s_to_hold |-> interval_timer_o == periods_i.hold_period_value
      && status_o.interval_timer_on;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not load hold period");
  property p_first;
    s_to_first |-> $past(interval_timer_o) == TMR_MAX
      && interval_timer_o == periods_i.first_approach_period_value;
  endproperty
  a_first: assert property (p_first)
    else $error("bad entry to first approach");
  property p_second;
    s_to_second |-> $past(interval_timer_o) == TMR_MAX
      && interval_timer_o == periods_i.second_approach_period_value;
  endproperty
  a_second: assert property (p_second)
    else $error("bad entry to second approach");
  property p_idle;
    ph != PHASE_CODE_IDLE ##1 ph == PHASE_CODE_IDLE
      |-> !status_o.interval_timer_on;
  endproperty
  a_idle: assert property (p_idle)
    else $error("timer still on in idle");
  property p_en;
    $stable(md) |-> status_o.approach_enable ==
      (md && (ph == PHASE_CODE_FIRST || ph == PHASE_CODE_SECOND));
  endproperty
  a_en: assert property (p_en)
    else $error("approach enable wrong for phase");
  // No write strobe means the width may only move while approaching.
  property p_fixed;
    (ph == PHASE_CODE_HOLD || ph == PHASE_CODE_IDLE) && !pw_lo_wr_i
      |=> $stable(pulse_width_value_o);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("width moved outside approach");
  property p_set1;
    $rose(f1) |-> pulse_width_value_o == first_target_width_i;
  endproperty
  a_set1: assert property (p_set1)
    else $error("first flag set without match");
  property p_set2;
    $rose(f2) |-> pulse_width_value_o == second_target_width_o;
  endproperty
  a_set2: assert property (p_set2)
    else $error("second flag set without match");
  property p_clr1;
    flag1_clr_i && ph == PHASE_CODE_IDLE |=> !f1;
  endproperty
  a_clr1: assert property (p_clr1)
    else $error("first flag not cleared");
  property p_mode_on;
    $rose(md) |=> !status_o.interval_timer_on;
  endproperty
  a_mode_on: assert property (p_mode_on)
    else $error("timer-on kept at mode entry");
  property p_mode_off;
    $fell(md) |=> ph == PHASE_CODE_IDLE;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("phase not idle after mode exit");
endmodule
bind pwha_core pwha_props u_props (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .cfg_i(cfg_i), .periods_i(periods_i),
  .first_target_width_i(first_target_width_i), .pw_lo_wr_i(pw_lo_wr_i),
  .flag1_clr_i(flag1_clr_i), .pulse_width_value_o(pulse_width_value_o),
  .second_target_width_o(second_target_width_o),
  .interval_timer_o(interval_timer_o), .status_o(status_o));
`default_nettype wire

// ### testbench/pwha_far.sv
// Model of the pins outside the controller: comparator and trigger.
// Assumes the bench calls one task at a time, all on rising edges.
`timescale 1ns/1ps
`default_nettype none
module pwha_far (
  input wire logic mclk_i,
  output logic overvoltage_interrupt_o,
  output logic pulse_trigger_o
);
  // The trigger pin idles high, so reset never sees a stray fall.
  initial begin
    overvoltage_interrupt_o = 1'h0;
    pulse_trigger_o = 1'h1;
  end
  // Drives the comparator pin level after the next rising edge.
  task automatic ovp(input logic lvl);
    @(posedge mclk_i);
    overvoltage_interrupt_o <= lvl;
  endtask
  // Low four clocks outlasts the three-stage sync; then high four.
  task automatic trig(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      pulse_trigger_o <= 1'h0;
      repeat (4) @(posedge mclk_i);
      pulse_trigger_o <= 1'h1;
      repeat (4) @(posedge mclk_i);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/pwha_core_tb.sv
// Self-checking bench for the approach controller and its pin model.
// Assumes a 125 MHz clock; inputs change only after rising edges.
`timescale 1ns/1ps
`default_nettype none
module pwha_core_tb
  import pwha_pkg::*;
;
  logic mclk_i = 1'h0;
  logic resetn_i = 1'h0;
  pwha_cfg_type cfg = '0;
  pwha_period_type per = '0;
  logic [PW_W-1:0] tgt1 = '0;
  logic [7:0] wb = '0;
  logic pwh = 1'h0, pwl = 1'h0, t2h = 1'h0, t2l = 1'h0;
  logic [3:0] ops = '0;
  logic [CNT_W-1:0] cw = '0;
  logic [STEP_W-1:0] sw = '0;
  logic ovp, trg;
  logic [PW_W-1:0] pw, t2o;
  logic [CNT_W-1:0] cnt;
  logic [STEP_W-1:0] stp;
  logic [TMR_W-1:0] tmr, t0;
  pwha_status_type st;
  int err_total = 0;
  int n_checks = 0;
  // Clock of 8 ns period.
  always #4 mclk_i = ~mclk_i;
  pwha_far u_far (.mclk_i(mclk_i), .overvoltage_interrupt_o(ovp),
    .pulse_trigger_o(trg));
  pwha_core u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_i(cfg),
    .periods_i(per), .first_target_width_i(tgt1), .wr_byte_i(wb),
    .pw_hi_wr_i(pwh), .pw_lo_wr_i(pwl), .tgt2_hi_wr_i(t2h),
    .tgt2_lo_wr_i(t2l), .field_wr_i(ops[3]), .trigger_count_wdata_i(cw),
    .step_size_wdata_i(sw), .timer_on_wr_i(ops[2]),
    .timer_on_wdata_i(1'h1), .flag1_clr_i(ops[1]), .flag2_clr_i(ops[0]),
    .overvoltage_interrupt_i(ovp), .pulse_trigger_input_i(trg),
    .pulse_width_value_o(pw), .second_target_width_o(t2o),
    .trigger_count_field_o(cnt), .step_size_field_o(stp),
    .interval_timer_o(tmr), .status_o(st));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // High byte first so the low write commits all nine bits.
  task automatic wr9(input logic [8:0] v, input logic t2);
    @(posedge mclk_i);
    {pwh, t2h, wb} <= {!t2, t2, 7'h00, v[8]};
    @(posedge mclk_i);
    {pwh, t2h, pwl, t2l, wb} <= {2'h0, !t2, t2, v[7:0]};
    @(posedge mclk_i);
    {pwl, t2l} <= 2'h0;
    @(negedge mclk_i);
  endtask
  // One-cycle strobes: field, timer-on, first clear, second clear.
  task automatic op(input logic [3:0] k, input logic [1:0] c,
      input logic [2:0] s);
    @(posedge mclk_i);
    {ops, cw, sw} <= {k, c, s};
    @(posedge mclk_i);
    ops <= 4'h0;
    @(negedge mclk_i);
  endtask
  // Bounded wait; the phase compare itself is the check.
  task automatic wait_ph(input logic [1:0] p);
    for (int i = 0; i < 3000 && st.timer_phase_field !== p; i++) begin
      @(negedge mclk_i);
    end
    chk(16'(st.timer_phase_field), 16'(p));
  endtask
  task automatic ck_pw(input int n, input logic [8:0] e);
    u_far.trig(n);
    @(negedge mclk_i);
    chk(16'(pw), 16'(e));
  endtask
  // A hang is cut short after twenty times the expected run length.
  initial begin
    #250000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'h1;
    @(negedge mclk_i);
    chk(16'(st.timer_phase_field), 16'(PHASE_CODE_IDLE));
    wr9(9'h190, 1'h0);
    chk(16'(pw), 16'h0190);
    wr9(9'h19A, 1'h1);
    chk(16'(t2o), 16'h019A);
    @(posedge mclk_i);
    tgt1 <= 9'h1A4;
    per <= {16'hFFE1, 16'hFE6F, 16'hFE6F};
    cfg <= {3'h1, 2'h0, 3'h1, ADJ_INC, 2'h0};
    op(4'h8, 2'h2, 3'h3);
    op(4'h4, 2'h2, 3'h3);
    @(posedge mclk_i);
    cfg.approach_mode_select <= 1'h1;
    op(4'h0, 2'h2, 3'h3);
    chk(16'(st.interval_timer_on), 16'h0);
    u_far.ovp(1'h1);
    wait_ph(PHASE_CODE_HOLD);
    ck_pw(2, 9'h190);
    wait_ph(PHASE_CODE_FIRST);
    wr9(9'h055, 1'h0);
    chk(16'(pw), 16'h0190);
    op(4'h8, 2'h0, 3'h0);
    chk(16'(stp), 16'h3);
    chk(16'(st.approach_enable), 16'h1);
    ck_pw(3, 9'h194);
    ck_pw(3, 9'h198);
    chk(16'(cnt), 16'h3);
    ck_pw(4, 9'h19C);
    ck_pw(8, 9'h1A4);
    chk(16'(st.first_target_reached_flag), 16'h1);
    ck_pw(4, 9'h1A4);
    wait_ph(PHASE_CODE_SECOND);
    ck_pw(8, 9'h19C);
    ck_pw(4, 9'h198);
    ck_pw(4, 9'h19A);
    chk(16'(st.second_target_reached_flag), 16'h1);
    wait_ph(PHASE_CODE_IDLE);
    chk(16'(st.approach_enable), 16'h0);
    ck_pw(2, 9'h19A);
    op(4'h2, 2'h0, 3'h7);
    chk(16'(st.first_target_reached_flag), 16'h0);
    wr9(9'h1FD, 1'h0);
    op(4'h8, 2'h0, 3'h7);
    @(posedge mclk_i);
    tgt1 <= 9'h1FF;
    per.hold_period_value <= 16'hFF00;
    cfg.hw_trigger_source_select <= 1'h1;
    cfg.timer_clock_select <= 2'h1;
    op(4'h4, 2'h0, 3'h7);
    wait_ph(PHASE_CODE_HOLD);
    chk(16'(st.second_target_reached_flag), 16'h0);
    t0 = tmr;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'(tmr - t0), 16'h0004);
    wait_ph(PHASE_CODE_FIRST);
    ck_pw(1, 9'h1FF);
    op(4'h1, 2'h0, 3'h7);
    chk(16'(st.first_target_reached_flag), 16'h1);
    @(posedge mclk_i);
    cfg.approach_mode_select <= 1'h0;
    op(4'h0, 2'h0, 3'h7);
    chk(16'(st.timer_phase_field), 16'(PHASE_CODE_IDLE));
    u_far.ovp(1'h0);
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'(st.first_target_reached_flag), 16'h0);
    // Third run: falling edge active, slowest timer clock, downward steps.
    @(posedge mclk_i);
    tgt1 <= 9'h1E0;
    per.hold_period_value <= 16'hFFF0;
    per.first_approach_period_value <= 16'hFFC0;
    cfg.hw_trigger_source_select <= 1'h0;
    cfg.overvoltage_edge_select <= 1'h0;
    cfg.timer_clock_select <= 2'h3;
    cfg.count_adjust_setting <= ADJ_DEC;
    cfg.step_adjust_setting <= ADJ_DEC;
    @(posedge mclk_i);
    cfg.approach_mode_select <= 1'h1;
    u_far.ovp(1'h1);
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'(st.timer_phase_field), 16'(PHASE_CODE_IDLE));
    u_far.ovp(1'h0);
    wait_ph(PHASE_CODE_HOLD);
    t0 = tmr;
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'(tmr - t0), 16'h0002);
    wait_ph(PHASE_CODE_FIRST);
    ck_pw(2, 9'h1EF);
    chk(16'(stp), 16'h6);
    chk(16'(cnt), 16'h0);
    ck_pw(1, 9'h1E8);
    end_of_test();
  end
endmodule
`default_nettype wire
